/* File: core/hmab_pkg.sv */
// Package of register offsets, banks, field positions and reset values for the monitor bank.
package hmab_pkg;
  localparam logic [2:0] BANK_AUX    = 3'h2;
  localparam logic [2:0] BANK_STATUS = 3'h4;
  localparam logic [6:0] OFS_AUX_READ_HIGH = 7'h50;
  localparam logic [6:0] OFS_AUX_READ_LOW  = 7'h51;
  localparam logic [6:0] OFS_AUX_CONFIG    = 7'h52;
  localparam logic [6:0] OFS_AUX_HYST_HIGH = 7'h53;
  localparam logic [6:0] OFS_AUX_HYST_LOW  = 7'h54;
  localparam logic [6:0] OFS_AUX_OVT_HIGH  = 7'h55;
  localparam logic [6:0] OFS_AUX_OVT_LOW   = 7'h56;
  localparam logic [6:0] OFS_ALARM_STATUS  = 7'h50;
  localparam logic [6:0] OFS_MGMT_MASK     = 7'h51;
  localparam logic [6:0] OFS_BEEP_CTRL     = 7'h53;
  localparam logic [6:0] OFS_SYS_OFFSET    = 7'h54;
  localparam logic [6:0] OFS_CPU_OFFSET    = 7'h55;
  localparam logic [6:0] OFS_AUX_OFFSET    = 7'h56;
  localparam logic [6:0] OFS_LIVE_FIRST    = 7'h59;
  localparam logic [6:0] OFS_LIVE_SECOND   = 7'h5A;
  localparam logic [6:0] OFS_LIVE_THIRD    = 7'h5B;
  localparam logic [7:0] RST_AUX_CONFIG    = 8'h00;
  localparam logic [7:0] RST_AUX_HYST_HIGH = 8'h4B;
  localparam logic [7:0] RST_AUX_OVT_HIGH  = 8'h50;
  localparam logic [7:0] RST_MASK          = 8'h13;
  localparam logic [7:0] RST_ZERO          = 8'h00;
  localparam logic [7:0] CFG_WR_MASK       = 8'h1B;
  localparam logic [7:0] HALF_BIT_MASK     = 8'h80;
  localparam logic [7:0] MASK_WR_MASK      = 8'h13;
  localparam logic [7:0] BEEP_WR_MASK      = 8'h23;
  localparam logic [7:0] ALARM_USED_MASK   = 8'h37;
  localparam int CFG_STOP_BIT   = 0;
  localparam int CFG_MODE_BIT   = 1;
  localparam int CFG_FAULT_LSB  = 3;
  localparam int BEEP_STBY_BIT  = 0;
  localparam int BEEP_BAT_BIT   = 1;
  localparam int BEEP_USER_BIT  = 5;
endpackage : hmab_pkg

/* File: core/hmab_hyst.sv */
// Hysteresis comparator that sets above a high threshold and clears below a low one.
`timescale 1ns/100ps
`default_nettype none
module hmab_hyst (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Value and thresholds.
  input  wire logic [8:0] value,
  input  wire logic [8:0] over_limit,
  input  wire logic [8:0] hyst_limit,
  // Status.
  output logic            over
);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      over <= 1'b0;
    end else if (value > over_limit) begin
      over <= 1'b1;
    end else if (value < hyst_limit) begin
      over <= 1'b0;
    end
  end
endmodule // hmab_hyst
`default_nettype wire

/* File: core/hmab_top.sv */
// Alarm, status, threshold and offset register bank of the hardware monitor.
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module hmab_top (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Register port.
  input  wire logic [2:0] reg_bank,
  input  wire logic [6:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Temperature samples and limits, nine bits in half degrees, and the aux sample strobe.
  input  wire logic [8:0] aux_temp_input,
  input  wire logic [8:0] cpu_temp_input,
  input  wire logic [8:0] sys_temp_input,
  input  wire logic [8:0] cpu_over_limit,
  input  wire logic [8:0] cpu_hyst_limit,
  input  wire logic [8:0] sys_over_limit,
  input  wire logic [8:0] sys_hyst_limit,
  input  wire logic       aux_temp_sample,
  // Fan count violations.
  input  wire logic       cpu_fan_tach_first,
  input  wire logic       cpu_fan_tach_second,
  input  wire logic       sys_fan_tach,
  input  wire logic       aux_fan_tach_first,
  input  wire logic       aux_fan_tach_second,
  // Fan full-speed warnings.
  input  wire logic       warn_cpu_fan_first,
  input  wire logic       warn_sys_fan,
  input  wire logic       warn_cpu_fan_second,
  input  wire logic       warn_aux_fan,
  // Voltage range violations.
  input  wire logic       main_3v3_rail,
  input  wire logic       analog_supply,
  input  wire logic       voltage_input_first,
  input  wire logic       core_voltage,
  input  wire logic       voltage_input_second,
  input  wire logic       voltage_input_third,
  input  wire logic       voltage_input_fourth,
  input  wire logic       battery_voltage,
  input  wire logic       standby_rail,
  // Chassis intrusion event.
  input  wire logic       case_open,
  // Outputs.
  output logic            overtemp_output_n,
  output logic            mgmt_interrupt_n,
  output logic            beeper
);
  logic [7:0] aux_config_reg;
  logic [7:0] aux_hyst_high_reg;
  logic [7:0] aux_hyst_low_reg;
  logic [7:0] aux_ovt_high_reg;
  logic [7:0] aux_ovt_low_reg;
  logic [7:0] mask_reg;
  logic [7:0] beep_reg;
  logic [7:0] sys_offset_reg;
  logic [7:0] cpu_offset_reg;
  logic [7:0] aux_offset_reg;
  logic [7:0] alarm_reg;
  logic [7:0] alarm_next;
  logic [8:0] aux_read_reg;
  logic [1:0] fault_cnt_reg;
  logic       aux_over_reg;
  logic       case_latch_reg;
  logic       cpu_over;
  logic       sys_over;
  logic       aux_over;
  logic [8:0] aux_hyst;
  logic [8:0] aux_ovt;
  logic [8:0] aux_sum;
  logic [7:0] live_first;
  logic [7:0] live_second;
  logic [7:0] live_third;
  logic [7:0] rd_next;
  logic       wr_aux;
  logic       wr_stat;
  logic       ovt_rd_clr;
  logic       aux_sampling;

  assign wr_aux  = reg_wr && (reg_bank == hmab_pkg::BANK_AUX);
  assign wr_stat = reg_wr && (reg_bank == hmab_pkg::BANK_STATUS);
  assign ovt_rd_clr   = aux_config_reg[hmab_pkg::CFG_MODE_BIT] && reg_rd &&
                        (reg_bank == hmab_pkg::BANK_AUX) &&
                        (reg_addr == hmab_pkg::OFS_AUX_READ_HIGH);
  assign aux_sampling = aux_temp_sample && !aux_config_reg[hmab_pkg::CFG_STOP_BIT];
  assign aux_hyst = {aux_hyst_high_reg, aux_hyst_low_reg[7]};
  assign aux_ovt  = {aux_ovt_high_reg, aux_ovt_low_reg[7]};
  assign aux_sum  = aux_temp_input + {1'b0, aux_offset_reg};

  // Writable registers; reserved bits are forced to zero.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aux_config_reg    <= hmab_pkg::RST_AUX_CONFIG;
      aux_hyst_high_reg <= hmab_pkg::RST_AUX_HYST_HIGH;
      aux_hyst_low_reg  <= hmab_pkg::RST_ZERO;
      aux_ovt_high_reg  <= hmab_pkg::RST_AUX_OVT_HIGH;
      aux_ovt_low_reg   <= hmab_pkg::RST_ZERO;
      mask_reg          <= hmab_pkg::RST_MASK;
      beep_reg          <= hmab_pkg::RST_ZERO;
      sys_offset_reg    <= hmab_pkg::RST_ZERO;
      cpu_offset_reg    <= hmab_pkg::RST_ZERO;
      aux_offset_reg    <= hmab_pkg::RST_ZERO;
    end else begin
      if (wr_aux) begin
        unique case (reg_addr)
          hmab_pkg::OFS_AUX_CONFIG: aux_config_reg <= reg_wdata & hmab_pkg::CFG_WR_MASK;
          hmab_pkg::OFS_AUX_HYST_HIGH: aux_hyst_high_reg <= reg_wdata;
          hmab_pkg::OFS_AUX_HYST_LOW: aux_hyst_low_reg <= reg_wdata & hmab_pkg::HALF_BIT_MASK;
          hmab_pkg::OFS_AUX_OVT_HIGH: aux_ovt_high_reg <= reg_wdata;
          hmab_pkg::OFS_AUX_OVT_LOW: aux_ovt_low_reg <= reg_wdata & hmab_pkg::HALF_BIT_MASK;
          default: ;
        endcase
      end
      if (wr_stat) begin
        unique case (reg_addr)
          hmab_pkg::OFS_MGMT_MASK: mask_reg <= reg_wdata & hmab_pkg::MASK_WR_MASK;
          hmab_pkg::OFS_BEEP_CTRL: beep_reg <= reg_wdata & hmab_pkg::BEEP_WR_MASK;
          hmab_pkg::OFS_SYS_OFFSET: sys_offset_reg <= reg_wdata;
          hmab_pkg::OFS_CPU_OFFSET: cpu_offset_reg <= reg_wdata;
          hmab_pkg::OFS_AUX_OFFSET: aux_offset_reg <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // Aux reading is captured only while monitoring is enabled.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aux_read_reg <= 9'h000;
    end else if (aux_temp_sample && !aux_config_reg[hmab_pkg::CFG_STOP_BIT]) begin
      aux_read_reg <= aux_sum;
    end
  end

  // Fault counter and over-temperature output; a tripping sample wins over a read clear.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fault_cnt_reg <= 2'h0;
      aux_over_reg  <= 1'b0;
    end else begin
      if (ovt_rd_clr) begin
        aux_over_reg <= 1'b0;
      end
      if (aux_sampling) begin
        if (aux_sum > aux_ovt) begin
          if (fault_cnt_reg == aux_config_reg[hmab_pkg::CFG_FAULT_LSB +: 2]) begin
            aux_over_reg <= 1'b1;
          end else begin
            fault_cnt_reg <= fault_cnt_reg + 2'h1;
          end
        end else begin
          fault_cnt_reg <= 2'h0;
          if (!aux_config_reg[hmab_pkg::CFG_MODE_BIT] && aux_sum < aux_hyst) begin
            aux_over_reg <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      overtemp_output_n <= 1'b1;
    end else begin
      overtemp_output_n <= !aux_over_reg;
    end
  end

  hmab_hyst u_cpu_hyst (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .value      (cpu_temp_input + {1'b0, cpu_offset_reg}),
    .over_limit (cpu_over_limit),
    .hyst_limit (cpu_hyst_limit),
    .over       (cpu_over)
  );
  hmab_hyst u_sys_hyst (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .value      (sys_temp_input + {1'b0, sys_offset_reg}),
    .over_limit (sys_over_limit),
    .hyst_limit (sys_hyst_limit),
    .over       (sys_over)
  );
  hmab_hyst u_aux_hyst (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .value      (aux_read_reg),
    .over_limit (aux_ovt),
    .hyst_limit (aux_hyst),
    .over       (aux_over)
  );

  // Sticky alarm bits; a new event wins over a read clear.
  always_comb begin
    alarm_next = alarm_reg;
    if (reg_rd && reg_bank == hmab_pkg::BANK_STATUS && reg_addr == hmab_pkg::OFS_ALARM_STATUS) begin
      alarm_next = 8'h00;
    end
    alarm_next[5] = alarm_next[5] | aux_fan_tach_second;
    alarm_next[4] = alarm_next[4] | cpu_fan_tach_second;
    alarm_next[2] = alarm_next[2] | warn_aux_fan;
    alarm_next[1] = alarm_next[1] | battery_voltage;
    alarm_next[0] = alarm_next[0] | standby_rail;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      alarm_reg <= 8'h00;
    end else begin
      alarm_reg <= alarm_next & hmab_pkg::ALARM_USED_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mgmt_interrupt_n <= 1'b1;
    end else begin
      mgmt_interrupt_n <= ~|(alarm_reg & ~mask_reg);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      beeper <= 1'b0;
    end else begin
      beeper <= beep_reg[hmab_pkg::BEEP_USER_BIT] |
                (beep_reg[hmab_pkg::BEEP_BAT_BIT] & battery_voltage) |
                (beep_reg[hmab_pkg::BEEP_STBY_BIT] & standby_rail);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      case_latch_reg <= 1'b0;
    end else if (case_open) begin
      case_latch_reg <= 1'b1;
    end
  end

  assign live_first  = {cpu_fan_tach_first, sys_fan_tach, cpu_over, sys_over,
                        main_3v3_rail, analog_supply, voltage_input_first, core_voltage};
  assign live_second = {warn_cpu_fan_first, warn_sys_fan, aux_over, case_latch_reg,
                        aux_fan_tach_first, cpu_fan_tach_second, warn_cpu_fan_second,
                        voltage_input_second};
  assign live_third  = {aux_fan_tach_second, 1'b0, voltage_input_third, voltage_input_fourth,
                        1'b0, warn_aux_fan, battery_voltage, standby_rail};

  // Read mux; unmapped offsets read zero.
  always_comb begin
    rd_next = 8'h00;
    if (reg_bank == hmab_pkg::BANK_AUX) begin
      unique case (reg_addr)
        hmab_pkg::OFS_AUX_READ_HIGH: rd_next = aux_read_reg[8:1];
        hmab_pkg::OFS_AUX_READ_LOW: rd_next = {aux_read_reg[0], 7'h00};
        hmab_pkg::OFS_AUX_CONFIG: rd_next = aux_config_reg;
        hmab_pkg::OFS_AUX_HYST_HIGH: rd_next = aux_hyst_high_reg;
        hmab_pkg::OFS_AUX_HYST_LOW: rd_next = aux_hyst_low_reg;
        hmab_pkg::OFS_AUX_OVT_HIGH: rd_next = aux_ovt_high_reg;
        hmab_pkg::OFS_AUX_OVT_LOW: rd_next = aux_ovt_low_reg;
        default: rd_next = 8'h00;
      endcase
    end else if (reg_bank == hmab_pkg::BANK_STATUS) begin
      unique case (reg_addr)
        hmab_pkg::OFS_ALARM_STATUS: rd_next = alarm_reg;
        hmab_pkg::OFS_MGMT_MASK: rd_next = mask_reg;
        hmab_pkg::OFS_BEEP_CTRL: rd_next = beep_reg;
        hmab_pkg::OFS_SYS_OFFSET: rd_next = sys_offset_reg;
        hmab_pkg::OFS_CPU_OFFSET: rd_next = cpu_offset_reg;
        hmab_pkg::OFS_AUX_OFFSET: rd_next = aux_offset_reg;
        hmab_pkg::OFS_LIVE_FIRST: rd_next = live_first;
        hmab_pkg::OFS_LIVE_SECOND: rd_next = live_second;
        hmab_pkg::OFS_LIVE_THIRD: rd_next = live_third;
        default: rd_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_next;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  a_mask_gates_irq: assert property (@(posedge clk) disable iff (sys_rst)
    ((alarm_reg & ~mask_reg) == 8'h00) |=> mgmt_interrupt_n)
    else $error("management interrupt asserted with all alarms masked");
  a_alarm_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    standby_rail |=> alarm_reg[0])
    else $error("standby alarm not latched");
  a_fan_alarm_set: assert property (@(posedge clk) disable iff (sys_rst)
    aux_fan_tach_second |=> alarm_reg[5])
    else $error("second aux fan alarm not latched");
  a_user_beep: assert property (@(posedge clk) disable iff (sys_rst)
    beep_reg[hmab_pkg::BEEP_USER_BIT] |=> beeper)
    else $error("user beep not driven");
  a_beep_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    (beep_reg == 8'h00) |=> !beeper)
    else $error("beeper active while disabled");
  a_stop_holds: assert property (@(posedge clk) disable iff (sys_rst)
    aux_config_reg[hmab_pkg::CFG_STOP_BIT] |=> $stable(aux_read_reg))
    else $error("aux reading changed while stopped");
  a_ovt_follows: assert property (@(posedge clk) disable iff (sys_rst)
    aux_over_reg |=> !overtemp_output_n)
    else $error("overtemp output not asserted");
  a_case_latched: assert property (@(posedge clk) disable iff (sys_rst)
    case_open |=> case_latch_reg [*2])
    else $error("case open not latched");
  a_ro_ignored: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_stat && reg_addr == hmab_pkg::OFS_LIVE_FIRST) |=> $stable(mask_reg))
    else $error("write to read-only register changed state");
  a_ovt_read_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (ovt_rd_clr && !aux_sampling) |=> !aux_over_reg)
    else $error("over-temperature not cleared by reading");
  a_cmp_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (aux_sampling && !aux_config_reg[hmab_pkg::CFG_MODE_BIT] && aux_sum < aux_hyst &&
     aux_sum <= aux_ovt) |=> !aux_over_reg)
    else $error("over-temperature not released below hysteresis");
  a_low_reserved: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_rd && reg_bank == hmab_pkg::BANK_AUX && reg_addr == hmab_pkg::OFS_AUX_READ_LOW) |=>
    (reg_rdata[6:0] == 7'h00))
    else $error("reserved reading bits not zero");
endmodule // hmab_top
`default_nettype wire

/* File: bench/hmab_host_model.sv */
// Host-side model that drives the banked register port of the monitor bank.
`timescale 1ns/100ps
`default_nettype none
module hmab_host_model (
  // Clock.
  input  wire logic       clk,
  // Register port.
  output logic      [2:0] reg_bank,
  output logic      [6:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_bank  = 3'h0;
    reg_addr  = 7'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // One-cycle write strobe beside bank, index and data.
  task automatic write(input logic [2:0] b, input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_bank  <= b;
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  // One-cycle read strobe; the data stand only in the following cycle.
  task automatic read(input logic [2:0] b, input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_bank <= b;
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
endmodule // hmab_host_model
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking testbench of the monitor alarm and status bank.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [2:0]  reg_bank;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [8:0]  aux_t = 9'h000;
  logic [8:0]  cpu_t = 9'h000;
  logic [8:0]  sys_t = 9'h000;
  logic [8:0]  ov_lim = 9'h1FF;
  logic [8:0]  hy_lim = 9'h000;
  logic        smp = 1'b0;
  logic        case_open = 1'b0;
  logic [17:0] viol = '0;
  logic        ovt_n;
  logic        mgmt_n;
  logic        beeper;
  logic [7:0]  rd;
  logic [7:0]  r2;
  logic [7:0]  r3;
  logic [23:0] exp24;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          cycles = 0;
  // Bank, index, reset value and writable bits of each register.
  localparam logic [25:0] REGS [17] = '{
    {3'h2, 7'h50, 8'h00, 8'h00}, {3'h2, 7'h51, 8'h00, 8'h00}, {3'h2, 7'h52, 8'h00, 8'h1B},
    {3'h2, 7'h53, 8'h4B, 8'hFF}, {3'h2, 7'h54, 8'h00, 8'h80}, {3'h2, 7'h55, 8'h50, 8'hFF},
    {3'h2, 7'h56, 8'h00, 8'h80}, {3'h4, 7'h50, 8'h00, 8'h00}, {3'h4, 7'h51, 8'h13, 8'h13},
    {3'h4, 7'h52, 8'h00, 8'h00}, {3'h4, 7'h53, 8'h00, 8'h23}, {3'h4, 7'h54, 8'h00, 8'hFF},
    {3'h4, 7'h55, 8'h00, 8'hFF}, {3'h4, 7'h56, 8'h00, 8'hFF}, {3'h4, 7'h59, 8'h00, 8'h00},
    {3'h4, 7'h5A, 8'h00, 8'h00}, {3'h4, 7'h5B, 8'h00, 8'h00}};
  // Live status bit position of each violation input, three registers side by side.
  localparam int POS [18] = '{7, 6, 3, 2, 1, 0, 15, 14, 11, 10, 9, 8, 23, 21, 20, 18, 17, 16};

  hmab_host_model host (.clk(clk), .reg_bank(reg_bank), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  hmab_top dut (.clk(clk), .sys_rst(sys_rst), .reg_bank(reg_bank), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .aux_temp_input(aux_t), .cpu_temp_input(cpu_t), .sys_temp_input(sys_t),
    .cpu_over_limit(ov_lim), .cpu_hyst_limit(hy_lim), .sys_over_limit(ov_lim),
    .sys_hyst_limit(hy_lim), .aux_temp_sample(smp),
    .cpu_fan_tach_first(viol[0]), .sys_fan_tach(viol[1]), .main_3v3_rail(viol[2]),
    .analog_supply(viol[3]), .voltage_input_first(viol[4]), .core_voltage(viol[5]),
    .warn_cpu_fan_first(viol[6]), .warn_sys_fan(viol[7]), .aux_fan_tach_first(viol[8]),
    .cpu_fan_tach_second(viol[9]), .warn_cpu_fan_second(viol[10]),
    .voltage_input_second(viol[11]), .aux_fan_tach_second(viol[12]),
    .voltage_input_third(viol[13]), .voltage_input_fourth(viol[14]), .warn_aux_fan(viol[15]),
    .battery_voltage(viol[16]), .standby_rail(viol[17]), .case_open(case_open),
    .overtemp_output_n(ovt_n), .mgmt_interrupt_n(mgmt_n), .beeper(beeper));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s is %h, expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic do_reset();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  task automatic drive(input logic [17:0] v);
    @(posedge clk);
    viol <= v;
  endtask

  task automatic pulse(input logic [17:0] v);
    drive(v);
    drive('0);
  endtask

  task automatic rchk(input logic [2:0] b, input logic [6:0] a, input logic [7:0] exp);
    host.read(b, a, rd);
    check(rd, exp, "register");
  endtask

  task automatic sample(input logic [8:0] v, input logic exp_n);
    @(posedge clk);
    aux_t <= v;
    smp   <= 1'b1;
    @(posedge clk);
    smp   <= 1'b0;
    settle();
    check({7'h00, ovt_n}, {7'h00, exp_n}, "overtemp");
  endtask

  task automatic temps(input logic [8:0] c, input logic [8:0] s, input logic [7:0] exp);
    @(posedge clk);
    cpu_t <= c;
    sys_t <= s;
    settle();
    rchk(3'h4, 7'h59, exp);
  endtask

  task automatic reg_pass(input logic wr, input logic [7:0] pat);
    logic [25:0] e;
    for (int i = 0; i < 17; i++) begin
      e = REGS[i];
      if (wr) begin
        host.write(e[25:23], e[22:16], pat);
      end
      rchk(e[25:23], e[22:16], wr ? ((e[15:8] & ~e[7:0]) | (pat & e[7:0])) : e[15:8]);
    end
  endtask

  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    reg_pass(1'b0, 8'h00);
    reg_pass(1'b1, 8'hFF);
    settle();
    check({7'h00, beeper}, 8'h01, "beeper");
    reg_pass(1'b1, 8'h00);
    settle();
    check({7'h00, beeper}, 8'h00, "beeper");
    do_reset();
    reg_pass(1'b0, 8'h00);
    $display("Test registers finished");
    do_reset();
    host.write(3'h4, 7'h56, 8'h02);
    sample(9'h0A5, 1'b0);
    rchk(3'h2, 7'h50, 8'h53);
    rchk(3'h2, 7'h51, 8'h80);
    sample(9'h098, 1'b0);
    sample(9'h090, 1'b1);
    host.write(3'h2, 7'h52, 8'h08);
    sample(9'h0A5, 1'b1);
    sample(9'h090, 1'b1);
    sample(9'h0A5, 1'b1);
    sample(9'h0A5, 1'b0);
    host.write(3'h2, 7'h52, 8'h00);
    sample(9'h090, 1'b1);
    host.write(3'h2, 7'h52, 8'h02);
    sample(9'h0A5, 1'b0);
    sample(9'h090, 1'b0);
    host.read(3'h2, 7'h50, rd);
    settle();
    check({7'h00, ovt_n}, 8'h01, "overtemp");
    do_reset();
    host.write(3'h2, 7'h52, 8'h01);
    sample(9'h0A5, 1'b1);
    rchk(3'h2, 7'h50, 8'h00);
    do_reset();
    host.write(3'h2, 7'h55, 8'h40);
    host.write(3'h2, 7'h56, 8'h80);
    host.write(3'h2, 7'h53, 8'h3F);
    host.write(3'h2, 7'h54, 8'h80);
    sample(9'h082, 1'b0);
    sample(9'h07E, 1'b1);
    $display("Test aux temperature finished");
    do_reset();
    pulse(18'h10200);
    settle();
    check({7'h00, mgmt_n}, 8'h01, "interrupt");
    pulse(18'h01000);
    settle();
    check({7'h00, mgmt_n}, 8'h00, "interrupt");
    rchk(3'h4, 7'h50, 8'h32);
    rchk(3'h4, 7'h50, 8'h00);
    check({7'h00, mgmt_n}, 8'h01, "interrupt");
    host.write(3'h4, 7'h51, 8'h00);
    pulse(18'h28000);
    settle();
    check({7'h00, mgmt_n}, 8'h00, "interrupt");
    rchk(3'h4, 7'h50, 8'h05);
    $display("Test alarms finished");
    do_reset();
    drive(18'h10000);
    settle();
    check({7'h00, beeper}, 8'h00, "beeper");
    host.write(3'h4, 7'h53, 8'h02);
    settle();
    check({7'h00, beeper}, 8'h01, "beeper");
    host.write(3'h4, 7'h53, 8'h01);
    settle();
    check({7'h00, beeper}, 8'h00, "beeper");
    drive(18'h30000);
    settle();
    check({7'h00, beeper}, 8'h01, "beeper");
    drive('0);
    $display("Test beeper finished");
    do_reset();
    @(posedge clk);
    ov_lim <= 9'h0A0;
    hy_lim <= 9'h096;
    host.write(3'h4, 7'h55, 8'h02);
    host.write(3'h4, 7'h54, 8'h0C);
    temps(9'h09F, 9'h095, 8'h30);
    temps(9'h095, 9'h08C, 8'h30);
    temps(9'h093, 9'h084, 8'h00);
    $display("Test temperature status finished");
    do_reset();
    for (int k = 0; k < 18; k++) begin
      drive(18'h00001 << k);
      settle();
      exp24 = 24'h000001 << POS[k];
      host.read(3'h4, 7'h59, rd);
      host.read(3'h4, 7'h5A, r2);
      host.read(3'h4, 7'h5B, r3);
      check(rd, exp24[7:0], "status one");
      check(r2, exp24[15:8], "status two");
      check(r3, exp24[23:16], "status three");
    end
    drive('0);
    @(posedge clk);
    case_open <= 1'b1;
    @(posedge clk);
    case_open <= 1'b0;
    settle();
    rchk(3'h4, 7'h5A, 8'h10);
    rchk(3'h4, 7'h5A, 8'h10);
    $display("Test live status finished");
    give_verdict();
  end
endmodule // tb
`default_nettype wire
